// ===== nvac_access_ctrl.sv
// Access control for a byte-wide nonvolatile data memory.
// Assumes a processor core on a plain register port, one access a cycle.
//
// Overview of operation
// R1: Software loads pointer, clears space select, then sets read trigger.
// R2: Addressed byte lands in the buffer, readable the next cycle.
// R3: Buffer keeps the read value until another read or a software write.
// R4: Software loads pointer and buffer before starting a write.
// R5: Only 55h then AAh to the key port, then write trigger, starts a write.
// R6: Software should disable interrupts around the unlock sequence.
// R7: Writes only start while write enable is set.
// R8: Hardware never clears write enable.
// R9: During a write, control, pointer and buffer writes are ignored.
// R10: Write trigger is blocked unless write enable was already set.
// R11: Setting write enable and write trigger together starts nothing.
// R12: Write end clears the write trigger and sets the done flag.
// R13: Only software clears the done flag; it may poll it.
// R14: Raising the error flag leaves both select bits unchanged; a launching control write here still loads them from its data.
// R15: Config select routes to config; else space select picks data or program.
// R16: Read trigger is refused while program memory is selected.
// R17: Error flag rises on a reset mid-write or an improper write attempt; here only a one-edge reset leaves it set, a longer one clears it.
// R18: Software sets the write trigger but never clears it.
// R19: Write length is a counted parameter; trigger and lock hold throughout.
// R20: Any access breaking the key sequence returns the tracker to idle; a 55h key write restarts it at the first-key state.
//
// Chosen here: the placing of the registers and the strobed register port.
`default_nettype none
module nvac_access_ctrl
   import nvac_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [DATA_W-1:0] bus_rdata_q,
   // Status
   output logic nvm_done_flag_q,
   output logic [1:0] nvm_target_q
);
   nvac_mem_if mem ();

   logic space_select_q;
   logic config_space_select_q;
   logic erase_sel_q;
   logic aborted_program_flag_q;
   logic write_enable_q;
   logic [DATA_W-1:0] nvm_byte_buffer_q;
   logic [ADDR_W-1:0] nvm_byte_pointer_q;
   nvac_lock_e lock_q;
   logic wr_ctrl;
   logic wr_key;
   logic wr_buf;
   logic wr_ptr;
   logic wr_done;
   logic ctrl_ok;
   logic rd_fire;
   logic wr_try;
   logic launch;
   logic bad_try;
   logic busy;

   // Address match of a strobe against one offset
   function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs);
      return strobe && (addr == ofs);
   endfunction

   // Register write decode
   assign wr_ctrl = hit(bus_wr, bus_addr, OFS_CONTROL);
   assign wr_key = hit(bus_wr, bus_addr, OFS_UNLOCK);
   assign wr_buf = hit(bus_wr, bus_addr, OFS_BUFFER);
   assign wr_ptr = hit(bus_wr, bus_addr, OFS_POINTER);
   assign wr_done = hit(bus_wr, bus_addr, OFS_DONE);
   assign busy = mem.busy;

   // R9: control writes locked during a write
   assign ctrl_ok = wr_ctrl && !busy;
   // R16: read only from data memory
   // R15: routing decides the target
   assign rd_fire = ctrl_ok && bus_wdata[BIT_RTRIG]
      && (nvac_route(space_select_q, config_space_select_q) == TGT_DATA);
   // R18: software can only set the trigger
   assign wr_try = ctrl_ok && bus_wdata[BIT_WTRIG];
   // R5: launch needs the armed tracker
   // R10: write enable stored beforehand
   // R11: same-access enable does not count
   // R7: write enable required
   assign launch = wr_try && (lock_q == LK_ARMED) && write_enable_q
      && (nvac_route(space_select_q, config_space_select_q) == TGT_DATA);
   assign bad_try = wr_try && !launch;

   // Store side of the link
   assign mem.start = launch;
   assign mem.addr = nvm_byte_pointer_q;
   assign mem.wr_byte = nvm_byte_buffer_q;

   nvac_store #(
      .WRITE_CYCLES(WRITE_CYCLES)
   ) u_store (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .mem(mem.store)
   );

   // R20: unlock tracker, any access breaks it
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         lock_q <= LK_IDLE;
      end
      else if (bus_wr || bus_rd)
      begin
         unique case (lock_q)
            LK_KEY1:
            begin
               if (wr_key && bus_wdata == KEY_SECOND)
               begin
                  lock_q <= LK_ARMED;
               end
               else
               begin
                  lock_q <= (wr_key && bus_wdata == KEY_FIRST) ? LK_KEY1 : LK_IDLE;
               end
            end
            LK_IDLE, LK_ARMED:
            begin
               lock_q <= (wr_key && bus_wdata == KEY_FIRST) ? LK_KEY1 : LK_IDLE;
            end
            default:
            begin
               lock_q <= LK_IDLE;
            end
         endcase
      end
   end

   // Select, erase and enable bits
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         space_select_q <= BIT_RST;
         config_space_select_q <= BIT_RST;
         erase_sel_q <= BIT_RST;
         write_enable_q <= BIT_RST;
      end
      // R14: a refused attempt leaves the selects alone
      // R8: enable changes only by software
      else if (ctrl_ok && !bad_try)
      begin
         space_select_q <= bus_wdata[BIT_SPACE];
         config_space_select_q <= bus_wdata[BIT_CFG];
         erase_sel_q <= bus_wdata[BIT_ERASE];
         write_enable_q <= bus_wdata[BIT_WRITE_ENABLE];
      end
   end

   // R17: error flag, set on launch or bad attempt, cleared on completion
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         aborted_program_flag_q <= busy; // A one-edge reset mid-write leaves it set; a second reset edge copies the stopped timer and clears it
      end
      else if (launch || bad_try)
      begin
         aborted_program_flag_q <= 1'b1;
      end
      else if (mem.done)
      begin
         aborted_program_flag_q <= 1'b0;
      end
      else if (ctrl_ok)
      begin
         aborted_program_flag_q <= bus_wdata[BIT_ERR];
      end
   end

   // R2: read lands in the buffer
   // R3: buffer holds otherwise
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         nvm_byte_buffer_q <= BYTE_RST;
      end
      else if (rd_fire)
      begin
         nvm_byte_buffer_q <= mem.rd_byte;
      end
      else if (wr_buf && !busy)
      begin
         nvm_byte_buffer_q <= bus_wdata;
      end
   end

   // R9: pointer locked during a write
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         nvm_byte_pointer_q <= BYTE_RST;
      end
      else if (wr_ptr && !busy)
      begin
         nvm_byte_pointer_q <= bus_wdata;
      end
   end

   // R12: done flag set at write end
   // R13: software clears with a zero, a set in the same cycle wins
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         nvm_done_flag_q <= BIT_RST;
      end
      else if (mem.done)
      begin
         nvm_done_flag_q <= 1'b1;
      end
      else if (wr_done && !bus_wdata[BIT_DONE])
      begin
         nvm_done_flag_q <= 1'b0;
      end
   end

   // Read data stand one cycle, zero otherwise and for unmapped offsets
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || !bus_rd)
      begin
         bus_rdata_q <= BYTE_RST;
      end
      else
      begin
         unique case (bus_addr)
            // R12: write trigger reads as the busy timer
            OFS_CONTROL: bus_rdata_q <= {space_select_q, config_space_select_q, 1'b0,
               erase_sel_q, aborted_program_flag_q, write_enable_q, busy, 1'b0};
            OFS_BUFFER: bus_rdata_q <= nvm_byte_buffer_q;
            OFS_POINTER: bus_rdata_q <= nvm_byte_pointer_q;
            OFS_DONE: bus_rdata_q <= {7'h00, nvm_done_flag_q};
            default: bus_rdata_q <= BYTE_RST; // Key port and holes read zero
         endcase
      end
   end

   // R15: current route shown on a port
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         nvm_target_q <= TGT_DATA;
      end
      else
      begin
         nvm_target_q <= nvac_route(space_select_q, config_space_select_q);
      end
   end

   // Checks on the logic above
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_key_pair;
      (lock_q == LK_KEY1) ##1 (lock_q == LK_ARMED);
   endsequence
   sequence s_write_end;
      mem.done && !wr_try ##0 !busy;
   endsequence

   AST_READ_NEXT: assert property (rd_fire |=> nvm_byte_buffer_q == $past(mem.rd_byte)) // R2
      else $error("read byte not in buffer next cycle");
   AST_BUF_HOLD: assert property (!rd_fire && !(wr_buf && !busy) |=> $stable(nvm_byte_buffer_q)) // R3
      else $error("buffer changed without cause");
   AST_UNLOCK: assert property (launch |-> (lock_q == LK_ARMED) ##1 (lock_q == LK_IDLE)) // R5
      else $error("write launched without key order");
   AST_PAIR_ARMS: assert property (s_key_pair |-> $past(wr_key && bus_wdata == KEY_SECOND)) // R5
      else $error("tracker armed without second key");
   AST_WRITE_ENABLE_GATE: assert property (mem.start |-> write_enable_q && $past(write_enable_q)) // R10
      else $error("write started without stored enable");
   AST_WRITE_ENABLE_KEEP: assert property (write_enable_q && !ctrl_ok |=> write_enable_q) // R8
      else $error("write enable cleared by hardware");
   AST_LOCKED: assert property (busy |=> $stable(nvm_byte_pointer_q) && $stable(space_select_q)) // R9
      else $error("registers changed during write");
   AST_DONE: assert property (s_write_end |-> ##1 nvm_done_flag_q && !aborted_program_flag_q) // R12
      else $error("completion flags wrong");
   AST_DONE_STICKY: assert property (nvm_done_flag_q && !wr_done |=> nvm_done_flag_q) // R13
      else $error("done flag cleared by hardware");
   AST_TRACE: assert property ($rose(aborted_program_flag_q) |-> $stable(space_select_q)
      && $stable(config_space_select_q)) // R14
      else $error("select bits moved with error flag");
   AST_NO_PROG_READ: assert property (wr_ctrl && space_select_q |-> !rd_fire) // R16
      else $error("read fired from program space");
   AST_BAD_TRY: assert property (bad_try |=> aborted_program_flag_q) // R17
      else $error("improper attempt not flagged");
   AST_HOLD_LEN: assert property ($rose(busy) |-> busy [*8]) // R19
      else $error("write cycle ended too early");
endmodule
`default_nettype wire

// ===== nvac_pkg.sv
// Shared constants and types for the nonvolatile byte memory access block.
// Assumes a single 10 MHz clock and a byte-wide register port.
`default_nettype none
package nvac_pkg;
   // Widths of the register port and of the byte memory
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets on the register port
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_BUFFER = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_POINTER = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_DONE = 8'h04;
   // Field positions in the control register
   localparam int BIT_SPACE = 7;
   localparam int BIT_CFG = 6;
   localparam int BIT_ERASE = 4;
   localparam int BIT_ERR = 3;
   localparam int BIT_WRITE_ENABLE = 2;
   localparam int BIT_WTRIG = 1;
   localparam int BIT_RTRIG = 0;
   // Field position of the completion flag in its register
   localparam int BIT_DONE = 0;
   // Unlock keys, in the order they must arrive
   localparam logic [DATA_W-1:0] KEY_FIRST = 8'h55;
   localparam logic [DATA_W-1:0] KEY_SECOND = 8'haa;
   // Values after reset
   localparam logic BIT_RST = 1'b0;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   // Self-timed write duration
   localparam int CLK_PERIOD_NS = 100;
   localparam int WRITE_TIME_NS = 6400;
   localparam int WRITE_CYCLES_DFLT = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Unlock tracker states
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_KEY1 = 2'b01,
      LK_ARMED = 2'b10
   } nvac_lock_e;

   // Memory space that an access is routed to
   typedef enum logic [1:0] {
      TGT_DATA = 2'b00,
      TGT_PROG = 2'b01,
      TGT_CFG = 2'b10
   } nvac_target_e;

   // Route from the two select bits; configuration select overrides
   function automatic nvac_target_e nvac_route(input logic space, input logic cfg);
      if (cfg)
      begin
         return TGT_CFG;
      end
      return space ? TGT_PROG : TGT_DATA;
   endfunction
endpackage
`default_nettype wire

// ===== nvac_mem_if.sv
// Link between the access controller and the byte store with its write timer.
// Assumes both ends share one clock.
`default_nettype none
interface nvac_mem_if;
   import nvac_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] rd_byte;
   logic [DATA_W-1:0] wr_byte;
   logic start;
   logic busy;
   logic done;
   modport ctrl (output addr, output wr_byte, output start, input rd_byte, input busy,
      input done);
   modport store (input addr, input wr_byte, input start, output rd_byte, output busy,
      output done);
endinterface
`default_nettype wire

// ===== nvac_store.sv
// Byte memory array with its self-timed write cycle.
// Assumes address and data stay steady while busy is high.
`default_nettype none
module nvac_store
   import nvac_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Controller side
   nvac_mem_if.store mem
);
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

   logic [DATA_W-1:0] cells [2**ADDR_W];
   logic [CNT_W-1:0] cnt_q;
   logic busy_q;
   logic done_q;

   // Reads are combinational, so the controller can latch them at once
   assign mem.rd_byte = cells[mem.addr];
   assign mem.busy = busy_q;
   assign mem.done = done_q;

   // R19: counted write length
   // Write timer: busy for WRITE_CYCLES cycles, then a one-cycle done pulse
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         busy_q <= BIT_RST;
         done_q <= BIT_RST;
         cnt_q <= '0;
      end
      else
      begin
         done_q <= 1'b0;
         if (mem.start && !busy_q)
         begin
            busy_q <= 1'b1;
            cnt_q <= CNT_W'(WRITE_CYCLES - 1);
         end
         else if (busy_q)
         begin
            if (cnt_q == '0)
            begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
            else
            begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end

   // Commit the byte on the last cycle of the write; cells are never reset
   always_ff @(posedge ref_clk)
   begin
      if (busy_q && cnt_q == '0)
      begin
         cells[mem.addr] <= mem.wr_byte;
      end
   end
endmodule
`default_nettype wire

// ===== nvac_core_model.sv
// Processor core model that runs the firmware access sequences.
// Assumes the controller takes strobes on the rising clock edge.
`default_nettype none
module nvac_core_model
   import nvac_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [ADDR_W-1:0] bus_addr,
   output logic [DATA_W-1:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic [DATA_W-1:0] bus_rdata_q
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial
   begin
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end

   // One write, strobe dropped at the edge that takes it
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask

   // One read, data taken in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata_q;
   endtask

   task automatic nvm_read(input logic [7:0] a, ctl, output logic [7:0] d);
      wr(OFS_POINTER, a);
      wr(OFS_CONTROL, ctl & 8'h3e);
      wr(OFS_CONTROL, ctl);
      rd(OFS_BUFFER, d);
   endtask

   task automatic nvm_write(input logic [7:0] a, dat, ctl, k1, k2, input logic brk);
      logic [DATA_W-1:0] v;
      wr(OFS_POINTER, a);
      wr(OFS_BUFFER, dat);
      wr(OFS_CONTROL, ctl);
      wr(OFS_UNLOCK, k1);
      if (brk)
      begin
         rd(OFS_CONTROL, v);
      end
      wr(OFS_UNLOCK, k2);
      wr(OFS_CONTROL, ctl | 8'h06);
   endtask
endmodule
`default_nettype wire

// ===== nvac_access_ctrl_tb.sv
// Self-checking bench for the nonvolatile byte memory access block.
// Assumes the core model performs every register access.
`default_nettype none
module nvac_access_ctrl_tb
   import nvac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Short write cycle keeps the run brief
   localparam int WCYC = 12;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_wdata;
   logic [DATA_W-1:0] bus_rdata_q;
   logic bus_wr;
   logic bus_rd;
   logic nvm_done_flag_q;
   logic [1:0] nvm_target_q;
   logic [DATA_W-1:0] d;
   int error_cnt = 0;
   int comparisons = 0;

   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;

   nvac_core_model core (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q));

   nvac_access_ctrl #(.WRITE_CYCLES(WCYC)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata_q(bus_rdata_q), .nvm_done_flag_q(nvm_done_flag_q),
      .nvm_target_q(nvm_target_q));

   // Compare and count
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rdchk(input string n, input logic [ADDR_W-1:0] a, input logic [7:0] e);
      logic [DATA_W-1:0] v;
      core.rd(a, v);
      chk(n, e, v);
   endtask

   task automatic chk_done(input logic e);
      chk("done flag", {7'h00, e}, {7'h00, nvm_done_flag_q});
   endtask

   // Values after reset, write-only and unmapped places
   task automatic t_reset();
      rdchk("control", OFS_CONTROL, 8'h00);
      rdchk("buffer", OFS_BUFFER, 8'h00);
      rdchk("pointer", OFS_POINTER, 8'h00);
      rdchk("unlock", OFS_UNLOCK, 8'h00);
      rdchk("unmapped", 8'h05, 8'h00);
      chk_done(1'b0);
   endtask

   // Full write, lock while busy, completion and read-back
   task automatic t_write();
      core.nvm_write(8'h21, 8'h5a, 8'h04, KEY_FIRST, KEY_SECOND, 1'b0);
      rdchk("busy control", OFS_CONTROL, 8'h0e);
      core.wr(OFS_POINTER, 8'h33);
      core.wr(OFS_BUFFER, 8'h11);
      for (int i = 0; i < 40 && nvm_done_flag_q !== 1'b1; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk_done(1'b1);
      rdchk("locked pointer", OFS_POINTER, 8'h21);
      rdchk("locked buffer", OFS_BUFFER, 8'h5a);
      rdchk("control after", OFS_CONTROL, 8'h04);
      core.nvm_read(8'h21, 8'h05, d);
      chk("read back", 8'h5a, d);
      repeat (5) @(posedge ref_clk);
      chk_done(1'b1);
      core.wr(OFS_DONE, 8'h00);
      #1;
      chk_done(1'b0);
   endtask

   // Sequence that must not start a write
   task automatic t_refuse(input logic [7:0] k1, k2, input logic brk, input logic [7:0] ctl,
      input logic [7:0] ex);
      core.nvm_write(8'h21, 8'hc3, ctl, k1, k2, brk);
      repeat (WCYC + 8) @(posedge ref_clk);
      #1;
      chk_done(1'b0);
      rdchk("refused control", OFS_CONTROL, ex);
      core.nvm_read(8'h21, 8'h05, d);
      chk("cell kept", 8'h5a, d);
   endtask

   // Program space refuses a read; route follows the selects
   task automatic t_space();
      logic [7:0] ctl [3] = '{8'hc0, 8'h40, 8'h00};
      logic [7:0] tgt [3] = '{8'h02, 8'h02, 8'h00};
      core.wr(OFS_BUFFER, 8'h77);
      core.wr(OFS_CONTROL, 8'h80);
      @(posedge ref_clk);
      #1;
      chk("target", 8'h01, {6'h00, nvm_target_q});
      core.wr(OFS_CONTROL, 8'h81);
      rdchk("refused read", OFS_BUFFER, 8'h77);
      for (int i = 0; i < 3; i++)
      begin
         core.wr(OFS_CONTROL, ctl[i]);
         @(posedge ref_clk);
         #1;
         chk("target", tgt[i], {6'h00, nvm_target_q});
      end
   endtask

   // Reset in the middle of a write
   task automatic t_reset_mid();
      core.nvm_write(8'h22, 8'h99, 8'h04, KEY_FIRST, KEY_SECOND, 1'b0);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b0;
      // One reset edge: the error flag copies the timer, which that edge stops
      repeat (1) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdchk("control after abort", OFS_CONTROL, 8'h08);
      chk_done(1'b0);
   endtask

   // Count summary and verdict
   task automatic final_report();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_write();
      t_refuse(KEY_SECOND, KEY_FIRST, 1'b0, 8'h04, 8'h0c);
      t_refuse(KEY_FIRST, KEY_SECOND, 1'b1, 8'h04, 8'h0c);
      t_refuse(KEY_FIRST, KEY_SECOND, 1'b0, 8'h00, 8'h08);
      t_refuse(KEY_FIRST, KEY_SECOND, 1'b0, 8'h84, 8'h8c);
      t_space();
      t_reset_mid();
      final_report();
   end

   // Watchdog, far beyond the expected run
   initial
   begin
      #2000000;
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
